// File: logic/fdi_port.sv
// Serial register port of the flash driver: bus target and register file.
`timescale 1ns/1ps
`include "fdi_defs.svh"

module fdi_port (
    input  wire logic       sys_clk,            // System clock, 200 MHz.
    input  wire logic       arst_n,             // Asynchronous reset, active low.
    input  wire logic       scl_in,             // Serial clock pin.
    input  wire logic       sda_in,             // Serial data pin level.
    input  wire logic       en_in,              // Enable pin.
    input  wire logic [7:0] fault_evt,          // Fault and information event pulses.
    output logic            sda_out,            // Serial data drive value.
    output logic            sda_oe,             // Serial data drive enable.
    output logic [1:0]      aux_pin_two_role,   // Second auxiliary pin role.
    output logic [1:0]      aux_pin_one_role,   // First auxiliary pin role.
    output logic [3:0]      flash_timeout_code, // Flash timer code.
    output logic [4:0]      flash_current_code, // Flash current code.
    output logic [2:0]      torch_current_code, // Torch current code.
    output logic [7:0]      fault_info          // Sticky fault bits.
);
    fdi_bus_if bus ();

    fdi_pkg::fdi_state_e state_r;   // Serial engine state.
    logic [3:0]          bitcnt_r;  // Bits moved in the current byte.
    logic [7:0]          shift_r;   // Receive shift register.
    logic [7:0]          tx_r;      // Transmit shift register.
    logic [7:0]          sub_r;     // Selected sub-address.
    logic                rw_r;      // Read when high.
    logic                nack_r;    // Controller refused the last read byte.
    logic                oe_r;      // Open-drain pull-down enable.
    logic [7:0]          pin_r;     // Pin role and flash timer register.
    logic [7:0]          cur_r;     // Flash and torch current register.
    logic [7:0]          fault_r;   // Fault information register.
    logic                byte_done; // Eighth bit captured.
    logic                wr_en;     // Data byte completes on this edge.
    logic                rd_load;   // Read byte is loaded on this edge.
    logic [7:0]          rd_addr;   // Register being loaded for a read.
    logic [7:0]          rd_data;   // Read mux output.
    logic [7:0]          fault_clr; // Bits reported by this read.

    // Fixed design code, held as a constant so that single bits can be picked.
    localparam logic [7:0] id_code = `FDI_DESIGN_INFO_VAL;

    fdi_line_cond u_cond (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .en_in   (en_in),
        .bus     (bus)
    );

    // ------------------------------------------------------------------
    // Transfer strobes
    // ------------------------------------------------------------------
    // Back-to-back reads step to the next sub-address after each acked byte.
    assign byte_done = (bitcnt_r == `FDI_BITS_PER_BYTE);
    assign wr_en     = bus.scl_fall && (state_r == fdi_pkg::ST_WDATA) && byte_done;
    assign rd_load   = bus.scl_fall && !bus.start && !bus.stop &&
                       (((state_r == fdi_pkg::ST_ADDR_ACK) && rw_r) ||
                        ((state_r == fdi_pkg::ST_RACK) && !nack_r));
    assign rd_addr   = (state_r == fdi_pkg::ST_RACK) ? sub_r + 8'h01 : sub_r;

    // Read mux; unmapped sub-addresses read as zero.
    always_comb begin
        unique case (rd_addr)
            `FDI_SUB_DESIGN_INFO: rd_data = `FDI_DESIGN_INFO_VAL;
            `FDI_SUB_PIN_TIMER:   rd_data = pin_r;
            `FDI_SUB_CURRENT:     rd_data = cur_r;
            `FDI_SUB_FAULT_INFO:  rd_data = fault_r;
            default:              rd_data = 8'h00;
        endcase
    end

    assign fault_clr = (rd_load && (rd_addr == `FDI_SUB_FAULT_INFO)) ? fault_r : 8'h00;

    // ------------------------------------------------------------------
    // Serial engine: state, counters and shifting
    // ------------------------------------------------------------------
    // Data is sampled on the rising clock and changed after the falling
    // clock, so the pin is never moved while the controller samples it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r  <= fdi_pkg::ST_IDLE;
            bitcnt_r <= 4'h0;
            shift_r  <= 8'h00;
            tx_r     <= 8'h00;
            sub_r    <= 8'h00;
            rw_r     <= 1'b0;
            nack_r   <= 1'b0;
            oe_r     <= 1'b0;
        end else if (bus.start) begin
            state_r  <= fdi_pkg::ST_ADDR;
            bitcnt_r <= 4'h0;
            oe_r     <= 1'b0;
        end else if (bus.stop) begin
            state_r  <= fdi_pkg::ST_IDLE;
            oe_r     <= 1'b0;
        end else if (bus.scl_rise) begin
            unique case (state_r)
                fdi_pkg::ST_ADDR, fdi_pkg::ST_SUB, fdi_pkg::ST_WDATA: begin
                    shift_r  <= {shift_r[6:0], bus.sda};
                    bitcnt_r <= bitcnt_r + 4'h1;
                end
                fdi_pkg::ST_RACK: nack_r <= bus.sda;
                default: ;
            endcase
        end else if (bus.scl_fall) begin
            unique case (state_r)
                fdi_pkg::ST_IDLE: ;
                fdi_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        bitcnt_r <= 4'h0;
                        if (shift_r[7:1] == `FDI_TARGET_ADDR) begin
                            rw_r    <= shift_r[0];
                            oe_r    <= 1'b1;
                            state_r <= fdi_pkg::ST_ADDR_ACK;
                        end else begin
                            state_r <= fdi_pkg::ST_IDLE;
                        end
                    end
                end
                fdi_pkg::ST_SUB: begin
                    if (byte_done) begin
                        sub_r    <= shift_r;
                        bitcnt_r <= 4'h0;
                        oe_r     <= 1'b1;
                        state_r  <= fdi_pkg::ST_SUB_ACK;
                    end
                end
                fdi_pkg::ST_WDATA: begin
                    if (byte_done) begin
                        bitcnt_r <= 4'h0;
                        oe_r     <= 1'b1;
                        state_r  <= fdi_pkg::ST_WDATA_ACK;
                    end
                end
                fdi_pkg::ST_SUB_ACK: begin
                    oe_r    <= 1'b0;
                    state_r <= fdi_pkg::ST_WDATA;
                end
                fdi_pkg::ST_WDATA_ACK: begin
                    oe_r    <= 1'b0;
                    sub_r   <= sub_r + 8'h01;
                    state_r <= fdi_pkg::ST_WDATA;
                end
                fdi_pkg::ST_ADDR_ACK, fdi_pkg::ST_RACK: begin
                    if (rd_load) begin
                        // Most significant bit goes out first.
                        sub_r    <= rd_addr;
                        oe_r     <= ~rd_data[7];
                        tx_r     <= {rd_data[6:0], 1'b0};
                        bitcnt_r <= 4'h1;
                        state_r  <= fdi_pkg::ST_RDATA;
                    end else if (state_r == fdi_pkg::ST_ADDR_ACK) begin
                        oe_r    <= 1'b0;
                        state_r <= fdi_pkg::ST_SUB;
                    end else begin
                        state_r <= fdi_pkg::ST_IDLE;
                    end
                end
                fdi_pkg::ST_RDATA: begin
                    if (byte_done) begin
                        oe_r    <= 1'b0;
                        state_r <= fdi_pkg::ST_RACK;
                    end else begin
                        oe_r     <= ~tx_r[7];
                        tx_r     <= {tx_r[6:0], 1'b0};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    // The enable edge restores defaults in-band; arst_n covers power-up.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_r <= `FDI_PIN_TIMER_RST;
            cur_r <= `FDI_CURRENT_RST;
        end else if (bus.en_rise) begin
            pin_r <= `FDI_PIN_TIMER_RST;
            cur_r <= `FDI_CURRENT_RST;
        end else if (wr_en) begin
            // Other sub-addresses are acknowledged and dropped.
            unique case (sub_r)
                `FDI_SUB_PIN_TIMER: pin_r <= shift_r;
                `FDI_SUB_CURRENT:   cur_r <= shift_r;
                default: ;
            endcase
        end
    end

    // Fault bits are sticky; a new event wins over a read clear.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_r <= `FDI_FAULT_RST;
        end else if (bus.en_rise) begin
            // An event in the enable cycle still sets its bit; earlier sticky bits are cleared.
            fault_r <= `FDI_FAULT_RST | fault_evt;
        end else begin
            fault_r <= (fault_r & ~fault_clr) | fault_evt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            sda_out <= 1'b0; // Open drain: only ever pulls low.
            sda_oe  <= oe_r;
        end
    end

    assign aux_pin_two_role   = pin_r[`FDI_PIN_TWO_MSB:`FDI_PIN_TWO_LSB];
    assign aux_pin_one_role   = pin_r[`FDI_PIN_ONE_MSB:`FDI_PIN_ONE_LSB];
    assign flash_timeout_code = pin_r[`FDI_TIMER_MSB:`FDI_TIMER_LSB];
    assign flash_current_code = cur_r[`FDI_FLASH_MSB:`FDI_FLASH_LSB];
    assign torch_current_code = cur_r[`FDI_TORCH_MSB:`FDI_TORCH_LSB];
    assign fault_info         = fault_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_addr_match: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(state_r == fdi_pkg::ST_ADDR_ACK) |-> $past(shift_r[7:1]) == `FDI_TARGET_ADDR)
        else $error("Acknowledged a foreign address.");
    a_data_ack: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !bus.en_rise |=> ##1 sda_oe)
        else $error("Write data byte not acknowledged.");
    a_id_msb: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_load && rd_addr == `FDI_SUB_DESIGN_INFO |=> ##1 sda_oe == ~id_code[7])
        else $error("Design code first bit wrong.");
    a_timer_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !bus.en_rise && sub_r == `FDI_SUB_PIN_TIMER
        |=> flash_timeout_code == $past(shift_r[3:0]) &&
            aux_pin_two_role == $past(shift_r[7:6]))
        else $error("Timer register write lost.");
    a_current_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !bus.en_rise && sub_r == `FDI_SUB_CURRENT
        |=> flash_current_code == $past(shift_r[7:3]) &&
            torch_current_code == $past(shift_r[2:0]))
        else $error("Current register write lost.");
    a_resv_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !bus.en_rise && sub_r != `FDI_SUB_PIN_TIMER && sub_r != `FDI_SUB_CURRENT
        |=> $stable(pin_r) && $stable(cur_r))
        else $error("Ignored write changed a register.");
    a_enable_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        bus.en_rise |=> torch_current_code == 3'h3 && flash_timeout_code == 4'hF &&
                        aux_pin_one_role == 2'h0 && fault_r == $past(fault_evt))
        else $error("Enable edge did not restore defaults.");
    a_fault_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_load && rd_addr == `FDI_SUB_FAULT_INFO && !bus.en_rise
        |=> fault_r == $past(fault_evt))
        else $error("Fault read did not clear reported bits.");
    a_nack_release: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == fdi_pkg::ST_RACK && bus.scl_fall && nack_r && !bus.start
        |=> state_r == fdi_pkg::ST_IDLE ##1 !sda_oe)
        else $error("Bus held after not-acknowledge.");
    // A foreign address must leave the data line alone until the next start.
    a_foreign_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == fdi_pkg::ST_ADDR && bus.scl_fall && byte_done &&
        shift_r[7:1] != `FDI_TARGET_ADDR |=> state_r == fdi_pkg::ST_IDLE ##1 !sda_oe)
        else $error("Foreign address not ignored.");
    a_pin_one_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && !bus.en_rise && sub_r == `FDI_SUB_PIN_TIMER
        |=> aux_pin_one_role == $past(shift_r[5:4]))
        else $error("First pin role write lost.");

    // Cover points for the main transfers.

    c_write_done: cover property (@(posedge sys_clk) disable iff (!arst_n)
        wr_en && sub_r == `FDI_SUB_CURRENT);
    c_read_fault: cover property (@(posedge sys_clk) disable iff (!arst_n)
        rd_load && rd_addr == `FDI_SUB_FAULT_INFO && fault_r != 8'h00);
    c_read_nack: cover property (@(posedge sys_clk) disable iff (!arst_n)
        state_r == fdi_pkg::ST_RACK && bus.scl_fall && nack_r);
    c_enable_reset: cover property (@(posedge sys_clk) disable iff (!arst_n)
        bus.en_rise);
    c_burst_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
        rd_load && state_r == fdi_pkg::ST_RACK);
endmodule : fdi_port

// File: logic/fdi_defs.svh
// Constants for the flash driver serial register port.
`ifndef FDI_DEFS_SVH
`define FDI_DEFS_SVH

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define FDI_TARGET_ADDR    7'h30
`define FDI_WR_ADDR_BYTE   8'h60
`define FDI_RD_ADDR_BYTE   8'h61

// ----------------------------------------------------------------------
// Register sub-addresses
// ----------------------------------------------------------------------
`define FDI_SUB_DESIGN_INFO 8'h00
`define FDI_SUB_PIN_TIMER   8'h02
`define FDI_SUB_CURRENT     8'h03
`define FDI_SUB_FAULT_INFO  8'h05

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FDI_PIN_TWO_MSB 7
`define FDI_PIN_TWO_LSB 6
`define FDI_PIN_ONE_MSB 5
`define FDI_PIN_ONE_LSB 4
`define FDI_TIMER_MSB   3
`define FDI_TIMER_LSB   0
`define FDI_FLASH_MSB   7
`define FDI_FLASH_LSB   3
`define FDI_TORCH_MSB   2
`define FDI_TORCH_LSB   0

// ----------------------------------------------------------------------
// Reset values and identity
// ----------------------------------------------------------------------
`define FDI_DESIGN_INFO_VAL 8'h5A // Arbitrary value; it names no real part.
`define FDI_PIN_TIMER_RST   8'h0F
`define FDI_CURRENT_RST     8'h03
`define FDI_FAULT_RST       8'h00

// ----------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------
`define FDI_BITS_PER_BYTE   4'h8

`endif

// File: logic/fdi_pkg.sv
// Types shared by the flash driver serial register port.
package fdi_pkg;

    // ------------------------------------------------------------------
    // Serial engine states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_SUB,
        ST_SUB_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } fdi_state_e;

endpackage : fdi_pkg

// File: logic/fdi_bus_if.sv
// Conditioned serial bus events passed from the line conditioner to the engine.
`timescale 1ns/1ps
interface fdi_bus_if;
    logic sda;      // Synchronised data level.
    logic scl_rise; // Clock rose this cycle.
    logic scl_fall; // Clock fell this cycle.
    logic start;    // Start or repeated start seen.
    logic stop;     // Stop seen.
    logic en_rise;  // Enable pin rose this cycle.

    modport cond (output sda, scl_rise, scl_fall, start, stop, en_rise);
    modport eng  (input  sda, scl_rise, scl_fall, start, stop, en_rise);
endinterface : fdi_bus_if

// File: logic/fdi_line_cond.sv
// Two-stage synchronisers and edge detection for the bus and enable pins.
`timescale 1ns/1ps
module fdi_line_cond (
    input  wire logic sys_clk, // System clock.
    input  wire logic arst_n,  // Asynchronous reset, active low.
    input  wire logic scl_in,  // Serial clock pin.
    input  wire logic sda_in,  // Serial data pin level.
    input  wire logic en_in,   // Enable pin.
    fdi_bus_if.cond   bus      // Conditioned events.
);
    logic [2:0] s1_r; // First stage, read only by the second.
    logic [2:0] s2_r; // Second stage.
    logic [2:0] s3_r; // Previous second-stage value.

    // ------------------------------------------------------------------
    // Synchronise scl, sda and en (bits 2, 1, 0).
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            s3_r <= 3'h7;
        end else begin
            s1_r <= {scl_in, sda_in, en_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Edges are taken from stages two and three only.
    assign bus.sda      = s2_r[1];
    assign bus.scl_rise = s2_r[2] & ~s3_r[2];
    assign bus.scl_fall = ~s2_r[2] & s3_r[2];
    assign bus.start    = s2_r[2] & s3_r[2] & s3_r[1] & ~s2_r[1];
    assign bus.stop     = s2_r[2] & s3_r[2] & ~s3_r[1] & s2_r[1];
    assign bus.en_rise  = s2_r[0] & ~s3_r[0];
endmodule : fdi_line_cond

// File: sim/fdi_host_model.sv
// Bus controller model that paces and drives the serial clock and data pins.
`timescale 1ns/1ps
`include "fdi_defs.svh"
module fdi_host_model (
    input  wire logic sys_clk, // Pacing clock.
    input  wire logic sda_w,   // Resolved data wire.
    output logic      scl,     // Serial clock drive.
    output logic      sda      // Data drive, high releases the wire.
);
    // Idle bus: both lines released to the pull-ups.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Six clocks a step keep every phase well above the synchroniser lag.
    task automatic tick();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : tick

    // Start condition, also used mid-transfer as a repeated start.
    task automatic start();
        sda = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda = 1'b0;
        tick();
        scl = 1'b0;
        tick();
    endtask : start

    // Stop condition: data rises while the clock is high.
    task automatic stop();
        sda = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda = 1'b1;
        tick();
    endtask : stop

    // One clock pulse; data moves only a full step after the clock falls.
    task automatic pulse(input logic b, output logic s);
        sda = b;
        tick();
        scl = 1'b1;
        tick();
        s = sda_w;
        scl = 1'b0;
        tick();
    endtask : pulse

    // Eight bits most significant first, then the answer bit.
    task automatic xbyte(input logic [7:0] b, input logic ans, output logic [7:0] d,
                         output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i], d[i]);
        end
        pulse(ans, s);
        ack = ~s;
    endtask : xbyte

    // Single-register write, or read through a repeated start ending in a not-acknowledge.
    task automatic access(input logic rd, input logic [7:0] sub, input logic [7:0] v,
                          output logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        logic a3;
        start();
        xbyte(`FDI_WR_ADDR_BYTE, 1'b1, d, a0);
        xbyte(sub, 1'b1, d, a1);
        if (rd) begin
            start();
            xbyte(`FDI_RD_ADDR_BYTE, 1'b1, d, a2);
            xbyte(8'hFF, 1'b1, d, a3);
        end else begin
            xbyte(v, 1'b1, d, a2);
        end
        stop();
        ok = a0 & a1 & a2;
    endtask : access
endmodule : fdi_host_model

// File: sim/fdi_port_tb.sv
// Self-checking bench for the flash driver serial register port.
`timescale 1ns/1ps
`include "fdi_defs.svh"
module fdi_port_tb;
    logic       sys_clk;
    logic       arst_n;
    logic       en_in;
    logic [7:0] fault_evt;
    logic       scl;
    logic       sda_h;
    logic       sda_out;
    logic       sda_oe;
    logic [1:0] aux_pin_two_role;
    logic [1:0] aux_pin_one_role;
    logic [3:0] flash_timeout_code;
    logic [4:0] flash_current_code;
    logic [2:0] torch_current_code;
    logic [7:0] fault_info;
    int         err_count;
    int         compares;
    wire logic  sda_w;
    wire logic [7:0] pin_reg = {aux_pin_two_role, aux_pin_one_role, flash_timeout_code};
    wire logic [7:0] cur_reg = {flash_current_code, torch_current_code};

    // Open-drain data wire: pulled up, low while either side pulls it.
    assign sda_w = sda_h & ~(sda_oe & ~sda_out);

    fdi_port u_fdi_port (
        .sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w), .en_in(en_in),
        .fault_evt(fault_evt), .sda_out(sda_out), .sda_oe(sda_oe),
        .aux_pin_two_role(aux_pin_two_role), .aux_pin_one_role(aux_pin_one_role),
        .flash_timeout_code(flash_timeout_code), .flash_current_code(flash_current_code),
        .torch_current_code(torch_current_code), .fault_info(fault_info)
    );
    fdi_host_model u_fdi_host_model (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl), .sda(sda_h));

    // 200 MHz system clock.
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Byte comparison; acknowledge bits reuse it zero-extended.
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_ack(input logic got, input logic exp);
        chk_val({7'h00, got}, {7'h00, exp});
    endtask : chk_ack

    // Register access wrappers that insist on a full acknowledge.
    task automatic wr(input logic [7:0] sub, input logic [7:0] v);
        logic [7:0] d;
        logic       ok;
        u_fdi_host_model.access(1'b0, sub, v, d, ok);
        chk_ack(ok, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] sub, output logic [7:0] d);
        logic ok;
        u_fdi_host_model.access(1'b1, sub, 8'h00, d, ok);
        chk_ack(ok, 1'b1);
    endtask : rd

    // Reset values and the fixed information code.
    task automatic t_reset();
        logic [7:0] d;
        chk_val(pin_reg, 8'h0F);
        chk_val(cur_reg, `FDI_CURRENT_RST);
        chk_val(fault_info, 8'h00);
        rd(`FDI_SUB_DESIGN_INFO, d);
        chk_val(d, `FDI_DESIGN_INFO_VAL);
    endtask : t_reset

    // Every pin role code, timer codes from lowest to highest, then readback.
    task automatic t_pin_timer();
        logic [7:0] v;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], ~i[1:0], 4'(i * 5)};
            wr(`FDI_SUB_PIN_TIMER, v);
            chk_val(8'(aux_pin_two_role), 8'(v[7:6]));
            chk_val(8'(aux_pin_one_role), 8'(v[5:4]));
            chk_val(8'(flash_timeout_code), 8'(v[3:0]));
            rd(`FDI_SUB_PIN_TIMER, d);
            chk_val(d, v);
        end
    endtask : t_pin_timer

    // Flash field at its extremes; torch field at 1 and 6.
    task automatic t_current();
        logic [7:0] v;
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? 8'hF9 : 8'h06;
            wr(`FDI_SUB_CURRENT, v);
            chk_val(8'(flash_current_code), 8'(v[7:3]));
            chk_val(8'(torch_current_code), 8'(v[2:0]));
            rd(`FDI_SUB_CURRENT, d);
            chk_val(d, v);
        end
    endtask : t_current

    // Writes to the read-only and a reserved place change nothing.
    task automatic t_readonly();
        logic [7:0] d;
        wr(`FDI_SUB_DESIGN_INFO, 8'hFF);
        wr(8'h04, 8'h77);
        rd(`FDI_SUB_DESIGN_INFO, d);
        chk_val(d, `FDI_DESIGN_INFO_VAL);
        chk_val(pin_reg, 8'hCF);
        chk_val(cur_reg, 8'h06);
    endtask : t_readonly

    // A neighbouring target address gets no answer and writes nothing.
    task automatic t_foreign();
        logic [7:0] d;
        logic       a;
        u_fdi_host_model.start();
        u_fdi_host_model.xbyte(8'h62, 1'b1, d, a);
        chk_ack(a, 1'b0);
        u_fdi_host_model.xbyte(`FDI_SUB_PIN_TIMER, 1'b1, d, a);
        u_fdi_host_model.xbyte(8'h00, 1'b1, d, a);
        u_fdi_host_model.stop();
        chk_val(pin_reg, 8'hCF);
    endtask : t_foreign

    // Fault bits stick until a read reports them, then clear.
    task automatic t_fault();
        logic [7:0] d;
        fault_evt = 8'hA5;
        @(posedge sys_clk);
        #1;
        fault_evt = 8'h00;
        @(posedge sys_clk);
        #1;
        chk_val(fault_info, 8'hA5);
        rd(`FDI_SUB_FAULT_INFO, d);
        chk_val(d, 8'hA5);
        chk_val(fault_info, 8'h00);
    endtask : t_fault

    // Two-byte read: a controller acknowledge steps on to the next register.
    task automatic t_burst();
        logic [7:0] d;
        logic       a;
        u_fdi_host_model.start();
        u_fdi_host_model.xbyte(`FDI_WR_ADDR_BYTE, 1'b1, d, a);
        u_fdi_host_model.xbyte(`FDI_SUB_PIN_TIMER, 1'b1, d, a);
        u_fdi_host_model.start();
        u_fdi_host_model.xbyte(`FDI_RD_ADDR_BYTE, 1'b1, d, a);
        chk_ack(a, 1'b1);
        u_fdi_host_model.xbyte(8'hFF, 1'b0, d, a);
        chk_val(d, 8'hCF);
        u_fdi_host_model.xbyte(8'hFF, 1'b1, d, a);
        chk_val(d, 8'h06);
        u_fdi_host_model.stop();
    endtask : t_burst

    // A rising enable pin restores defaults; the sync lag fits in six clocks.
    task automatic t_enable();
        en_in = 1'b0;
        fault_evt = 8'h11;
        @(posedge sys_clk);
        #1;
        fault_evt = 8'h00;
        repeat (5) @(posedge sys_clk);
        #1;
        chk_val(fault_info, 8'h11);
        en_in = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        chk_val(pin_reg, 8'h0F);
        chk_val(cur_reg, `FDI_CURRENT_RST);
        chk_val(fault_info, 8'h00);
    endtask : t_enable

    // Verdict and end of run.
    task automatic finish_test();
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // Main sequence: twelve reset clocks, four more before the first start.
    initial begin
        err_count = 0;
        compares = 0;
        arst_n = 1'b0;
        en_in = 1'b1;
        fault_evt = 8'h00;
        repeat (12) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        t_reset();
        t_pin_timer();
        t_current();
        t_readonly();
        t_foreign();
        t_fault();
        t_burst();
        t_enable();
        finish_test();
    end

    // Watchdog: the run needs about 60 us, near a seventh of this span.
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule : fdi_port_tb
